// ==== include/sbpp_map.svh ====
// constants for the synchronous pin port
// What this block does
// - a new byte goes out only when the sample buffer has room
// - per byte, all pins are sampled first, then the new byte is driven
// - one sample returned per byte written, lagging output by one byte
// - mode command 4 enables sync sampling, 0 resets the port
// - access starts by sampling, read strobe off, back on with new outputs
// - two states (drive, then setup) after outputs change, then write strobe pulses
// - read and write strobes are driven out on device pins
// - each pin is separately input or output; only outputs are driven
// - outputs hold the last written value while nothing new arrives
`ifndef SBPP_MAP_SVH
`define SBPP_MAP_SVH
`define SBPP_MODE_RESET 8'h00
`define SBPP_MODE_SYNC 8'h04
`define SBPP_DIR_RST 8'h00
`define SBPP_DATA_RST 8'h00
`define SBPP_PHASE_NS 25
`define SBPP_PHASE_CYC ((`SBPP_PHASE_NS * 40 + 999) / 1000)
`endif

// ==== include/sbpp_pkg.sv ====
// types for the synchronous pin port
`default_nettype none
package sbpp_pkg;
    typedef enum logic [2:0]
    {
        SBPP_IDLE = 3'b000,
        SBPP_SAMPLE = 3'b001,
        SBPP_RD_OFF = 3'b010,
        SBPP_DRIVE = 3'b011,
        SBPP_SETUP = 3'b100,
        SBPP_WR_ON = 3'b101,
        SBPP_WR_OFF = 3'b110
    } sbpp_state_e;
endpackage
`default_nettype wire

// ==== core/sbpp_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sbpp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            dout <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_r[i] == s3_r[i])
                    dout[i] <= s3_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/sbpp_port.sv ====
// synchronous sampling pin port, one channel
`timescale 1ns/1ps
`default_nettype none
`include "sbpp_map.svh"
module sbpp_port
    import sbpp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int PHASE_CYC = `SBPP_PHASE_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic mode_valid,
    input wire logic [7:0] mode_value,
    input wire logic [WIDTH-1:0] dir_out,
    input wire logic tx_valid,
    input wire logic [WIDTH-1:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [WIDTH-1:0] rx_data,
    input wire logic rx_ready,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic sync_mode
);
    // the phase counter is eight bits wide
    if (WIDTH < 1 || WIDTH > 8 || PHASE_CYC < 1 || PHASE_CYC > 256)
    begin : g_param_check
        $error("sbpp_port: unsupported parameters");
    end

    // ========================================
    // pin input synchroniser
    logic [WIDTH-1:0] pin_sync;

    sbpp_sync #(.WIDTH(WIDTH)) i_sbpp_sync (
        .clock(clock),
        .reset(reset),
        .din(pin_in),
        .dout(pin_sync)
    );

    // ========================================
    // mode control
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            sync_mode <= 1'b0;
        else if (mode_valid && mode_value == `SBPP_MODE_SYNC)
            sync_mode <= 1'b1;
        else if (mode_valid)
            sync_mode <= 1'b0;
    end

    wire mode_clear = mode_valid && mode_value == `SBPP_MODE_RESET;

    // ========================================
    // access sequencer
    sbpp_state_e state_r;
    sbpp_state_e state_nxt;
    logic [7:0] phase_r;
    logic [WIDTH-1:0] pend_r;
    logic [WIDTH-1:0] sample_r;
    wire phase_done = phase_r == 8'(PHASE_CYC - 1);
    // one-entry sample slot; a new byte starts only if it is free
    wire slot_free = !rx_valid || rx_ready;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            SBPP_IDLE:
                if (sync_mode && tx_valid && tx_ready)
                    state_nxt = SBPP_SAMPLE;
            SBPP_SAMPLE: state_nxt = SBPP_RD_OFF;
            SBPP_RD_OFF: state_nxt = SBPP_DRIVE;
            SBPP_DRIVE: state_nxt = SBPP_SETUP;
            SBPP_SETUP: state_nxt = SBPP_WR_ON;
            SBPP_WR_ON: state_nxt = SBPP_WR_OFF;
            SBPP_WR_OFF: state_nxt = SBPP_IDLE;
            default: state_nxt = SBPP_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_r <= SBPP_IDLE;
            phase_r <= 8'h00;
        end
        else if (mode_clear || !sync_mode)
        begin
            state_r <= SBPP_IDLE;
            phase_r <= 8'h00;
        end
        else if (state_r == SBPP_IDLE)
        begin
            state_r <= state_nxt;
            phase_r <= 8'h00;
        end
        else if (phase_done)
        begin
            state_r <= state_nxt;
            phase_r <= 8'h00;
        end
        else
            phase_r <= phase_r + 8'h01;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            tx_ready <= 1'b0;
        else
            tx_ready <= sync_mode && !mode_valid && state_nxt == SBPP_IDLE
                && state_r == SBPP_IDLE && slot_free
                && !(tx_valid && tx_ready);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pend_r <= WIDTH'(`SBPP_DATA_RST);
        else if (state_r == SBPP_IDLE && tx_valid && tx_ready)
            pend_r <= tx_data;
    end

    // ========================================
    // sample capture and return
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            sample_r <= '0;
        else if (state_r == SBPP_SAMPLE && phase_r == 8'h00)
            sample_r <= pin_sync;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rx_valid <= 1'b0;
            rx_data <= '0;
        end
        else if (mode_clear)
            rx_valid <= 1'b0;
        else if (state_r == SBPP_WR_OFF && phase_done)
        begin
            rx_valid <= 1'b1;
            rx_data <= sample_r;
        end
        else if (rx_ready)
            rx_valid <= 1'b0;
    end

    // ========================================
    // pin drive and strobes
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pin_out <= WIDTH'(`SBPP_DATA_RST);
        else if (state_r == SBPP_RD_OFF && phase_done)
            pin_out <= pend_r;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pin_oe <= WIDTH'(`SBPP_DIR_RST);
        else if (mode_clear)
            pin_oe <= WIDTH'(`SBPP_DIR_RST);
        else
            pin_oe <= sync_mode ? dir_out : WIDTH'(`SBPP_DIR_RST);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rd_strobe_n <= 1'b1;
            wr_strobe_n <= 1'b1;
        end
        else
        begin
            // a mode command other than 4 cuts the access, and no strobe may start during any mode command
            rd_strobe_n <= !(sync_mode && !mode_valid
                && (state_r == SBPP_SAMPLE && phase_done
                || state_r == SBPP_RD_OFF && !phase_done));
            wr_strobe_n <= !(sync_mode && !mode_valid
                && (state_r == SBPP_SETUP && phase_done
                || state_r == SBPP_WR_ON && !phase_done));
        end
    end

    // ========================================
    // checks
    sequence s_out_change;
        state_r == SBPP_RD_OFF && phase_done && !mode_clear && sync_mode;
    endsequence

    a_drive_after_sample: assert property (@(posedge clock) disable iff (reset)
        s_out_change |=> pin_out == pend_r)
        else $error("outputs not loaded from pending byte");

    a_hold_idle_out: assert property (@(posedge clock) disable iff (reset)
        state_r == SBPP_IDLE |=> $stable(pin_out))
        else $error("outputs changed while idle");

    a_strobe_rest: assert property (@(posedge clock) disable iff (reset)
        state_r == SBPP_IDLE && $past(state_r) == SBPP_IDLE
        |-> rd_strobe_n && wr_strobe_n)
        else $error("strobe active outside access");

    a_no_start_full: assert property (@(posedge clock) disable iff (reset)
        tx_ready |-> !rx_valid || $past(rx_ready) || $past(!rx_valid))
        else $error("start offered with full slot");

    a_one_sample: assert property (@(posedge clock) disable iff (reset)
        state_r == SBPP_WR_OFF && phase_done && !mode_clear
        |=> rx_valid && rx_data == sample_r)
        else $error("sample not returned");

    a_mode_sync: assert property (@(posedge clock) disable iff (reset)
        mode_valid && mode_value == `SBPP_MODE_SYNC |=> sync_mode)
        else $error("mode 4 did not enable");

    a_mode_clear: assert property (@(posedge clock) disable iff (reset)
        mode_clear |=> !sync_mode && pin_oe == '0)
        else $error("mode 0 did not reset");

    a_wr_after_setup: assert property (@(posedge clock) disable iff (reset)
        $rose(wr_strobe_n) |-> $past(state_r) == SBPP_WR_ON)
        else $error("write strobe ended out of step");

    a_dir_oe: assert property (@(posedge clock) disable iff (reset)
        sync_mode && !mode_valid && $past(sync_mode) && !$past(mode_valid)
        |-> pin_oe == $past(dir_out))
        else $error("output enable not following direction");

    a_rd_with_data: assert property (@(posedge clock) disable iff (reset)
        $rose(rd_strobe_n) |-> $changed(pin_out) || pin_out == pend_r)
        else $error("read strobe back without new data");
endmodule
`default_nettype wire

// ==== dv/sbpp_far_logic.sv ====
// far-side logic model: pulled-up pins, latch on write strobe
`timescale 1ns/1ps
`default_nettype none
module sbpp_far_logic (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    input wire logic wr_strobe_n,
    output logic [7:0] pin_in,
    output logic [7:0] latched
);
    // pins nobody drives float up through the internal pull-ups
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);
    // external logic clocked by the end of each write strobe
    always @(posedge wr_strobe_n)
        latched <= pin_in;
endmodule
`default_nettype wire

// ==== dv/sync_bitbang_pin_port_tb_top.sv ====
// self-checking bench for the synchronous pin port
`timescale 1ns/1ps
`default_nettype none
module sync_bitbang_pin_port_tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic mode_valid = 1'b0;
    logic [7:0] mode_value = 8'h00;
    logic [7:0] dir_out = 8'h00;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_ready = 1'b0;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic tx_ready, rx_valid, rd_strobe_n, wr_strobe_n, sync_mode;
    logic [7:0] rx_data, pin_in, pin_out, pin_oe, latched;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    sbpp_port #(.WIDTH(8), .PHASE_CYC(1)) i_sbpp_port (.clock(clock),
        .reset(reset), .mode_valid(mode_valid), .mode_value(mode_value),
        .dir_out(dir_out), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .rd_strobe_n(rd_strobe_n),
        .wr_strobe_n(wr_strobe_n), .sync_mode(sync_mode));
    sbpp_far_logic i_sbpp_far_logic (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .wr_strobe_n(wr_strobe_n),
        .pin_in(pin_in), .latched(latched));
    // ==========================================
    // helpers
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic set_mode(input logic [7:0] v);
        @(negedge clock);
        mode_valid = 1'b1;
        mode_value = v;
        @(negedge clock);
        mode_valid = 1'b0;
    endtask
    // one byte out; strobes checked cycle by cycle, sample checked once at the end
    task automatic send(input logic [7:0] d, input logic [7:0] exp,
        input bit consume);
        logic [7:0] rdv, wrv;
        int n;
        rdv = 8'hFF;
        wrv = 8'hFF;
        n = 0;
        @(negedge clock);
        tx_valid = 1'b1;
        tx_data = d;
        // ready is read off the edge; the next rising edge takes the byte
        while (tx_ready !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge clock);
        end
        chk("tx_ready", 8'h01, {7'h0, tx_ready});
        @(negedge clock);
        tx_valid = 1'b0;
        for (int k = 1; k < 8; k++)
        begin
            @(negedge clock);
            rdv[k] = rd_strobe_n;
            wrv[k] = wr_strobe_n;
            if (k == 2) chk("pin_out", d, pin_out);
            if (k == 5) chk("rx_valid early", 8'h00, {7'h0, rx_valid});
        end
        chk("rx_valid", 8'h01, {7'h0, rx_valid});
        chk("rx_data", exp, rx_data);
        chk("rd strobe", 8'hFD, rdv);
        chk("wr strobe", 8'hEF, wrv);
        if (consume)
        begin
            rx_ready = 1'b1;
            @(negedge clock);
            rx_ready = 1'b0;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_stream;
        set_mode(8'h04);
        dir_out = 8'hFF;
        repeat (8) @(negedge clock);
        send(8'hFF, 8'h00, 1);
        send(8'h55, 8'hFF, 1);
        send(8'hAA, 8'h55, 1);
        send(8'hAA, 8'hAA, 1);
        chk("far latch", 8'hAA, latched);
        $display("test stream done");
    endtask
    task automatic t_dir;
        dir_out = 8'h0F;
        ext_en = 8'hF0;
        ext_val = 8'hA0;
        repeat (6) @(negedge clock);
        chk("pin_oe", 8'h0F, pin_oe);
        send(8'h33, 8'hAA, 1);
        send(8'h33, 8'hA3, 1);
        chk("far latch dir", 8'hA3, latched);
        $display("test direction done");
    endtask
    task automatic t_full;
        send(8'h3C, 8'hA3, 0);
        tx_valid = 1'b1;
        tx_data = 8'hC3;
        repeat (20)
        begin
            @(negedge clock);
            chk("tx_ready full", 8'h00, {7'h0, tx_ready});
        end
        chk("pin hold", 8'h3C, pin_out);
        chk("rx hold", 8'hA3, rx_data);
        tx_valid = 1'b0;
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
        $display("test full done");
    endtask
    task automatic t_mode0;
        send(8'h5A, 8'hAC, 0);
        set_mode(8'h00);
        repeat (2) @(negedge clock);
        chk("rx dropped", 8'h00, {7'h0, rx_valid});
        chk("sync_mode off", 8'h00, {7'h0, sync_mode});
        chk("pin_oe off", 8'h00, pin_oe);
        chk("tx_ready off", 8'h00, {7'h0, tx_ready});
        chk("strobes idle", 8'h03, {6'h0, rd_strobe_n, wr_strobe_n});
        set_mode(8'h04);
        @(negedge clock);
        chk("sync_mode on", 8'h01, {7'h0, sync_mode});
        set_mode(8'h01);
        @(negedge clock);
        chk("other mode leaves", 8'h00, {7'h0, sync_mode});
        $display("test mode done");
    endtask
    // ==========================================
    // run control
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ceiling well above the roughly 140 cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            results();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_stream();
        t_dir();
        t_full();
        t_mode0();
        results();
    end
endmodule
`default_nettype wire
